// ==== depw_ctrl.sv ====
/*
 Data EEPROM page write controller: Wishbone register slave, page
 buffer, activation guard, write sequencer and EEPROM interrupt flags.
 Assumes a synchronous array port that takes one byte per nv_we pulse.
*/
`timescale 1ns/10ps
`include "depw_map.svh"
module depw_ctrl #(
    parameter int WR_TIME_US = `DEPW_WR_TIME_US,
    parameter int TICK_CYC = `DEPW_TICK_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt controller side
    input wire logic stack_full,
    input wire logic irq_service,
    output logic irq_vector_req,
    // EEPROM array program port
    output logic nv_we,
    output logic [10:0] nv_addr,
    output depw_pkg::depw_byte_t nv_wdata
);
    import depw_pkg::*;
    logic [6:0] eeprom_control_reg;
    logic [7:0] eeprom_addr_low_reg;
    logic [2:0] eeprom_addr_high_reg;
    logic [7:0] eeprom_data_reg;
    logic [7:0] pointer1_high_byte;
    logic [7:0] pointer2_high_byte;
    logic [4:0] irq_reg;
    depw_byte_t page_buf [16];
    logic [15:0] page_valid;
    logic page_full;
    logic write_enable_bit_q;
    logic armed;
    depw_state_t state;
    logic [3:0] walk_idx;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic acc;
    logic wr;
    logic sector_ok;
    logic ctrl_wr;
    logic start_ok;
    logic busy;
    logic done;
    logic load;
    logic write_enable_bit_fall;
    logic [3:0] offset;
    logic [6:0] page_sel;
    logic [7:0] rd_val;
    // Byte-lane write to one register
    function automatic logic hit(input logic [7:0] ofs);
        return wr && (wb_adr_i == ofs);
    endfunction
    // Bus decode; a request is taken once, the ack cycle masks a repeat
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign sector_ok = (pointer1_high_byte == `DEPW_SECTOR_CTRL) ||
                       (pointer2_high_byte == `DEPW_SECTOR_CTRL);
    assign ctrl_wr = hit(`DEPW_OFS_CTRL) && sector_ok;
    assign busy = (state != DEPW_IDLE);
    assign done = (state == DEPW_WAIT) && tmr_done;
    assign offset = eeprom_addr_low_reg[3:0];
    assign page_sel = {eeprom_addr_high_reg, eeprom_addr_low_reg[7:4]};
    assign write_enable_bit_fall = write_enable_bit_q && !eeprom_control_reg[`DEPW_CB_WRITE_ENABLE_BIT];
    // Start needs enable set in the previous access and an idle sequencer
    assign start_ok = ctrl_wr && wb_dat_i[`DEPW_CB_WR] &&
                      eeprom_control_reg[`DEPW_CB_WRITE_ENABLE_BIT] && armed && !busy;
    // Page loads: mode high, not full, not busy
    assign load = hit(`DEPW_OFS_DATA) && eeprom_control_reg[`DEPW_CB_MODE] &&
                  !page_full && !busy;
    // Bus answer one cycle after the request, read data registered with it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= {24'h00_0000, rd_val};
        end
    end
    // Read mux; control reads zero outside sector one, unmapped reads zero
    always_comb begin
        rd_val = 8'h00;
        case (wb_adr_i)
            `DEPW_OFS_CTRL: rd_val = sector_ok ? {1'b0, eeprom_control_reg} : 8'h00;
            `DEPW_OFS_ADDR_LO: rd_val = eeprom_addr_low_reg;
            `DEPW_OFS_ADDR_HI: rd_val = {5'h00, eeprom_addr_high_reg};
            `DEPW_OFS_DATA: rd_val = eeprom_data_reg;
            `DEPW_OFS_PTR1H: rd_val = pointer1_high_byte;
            `DEPW_OFS_PTR2H: rd_val = pointer2_high_byte;
            `DEPW_OFS_IRQ: rd_val = {3'h0, irq_reg};
            default: rd_val = 8'h00;
        endcase
    end
    // Control register; hardware end-of-cycle clear overrides software
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            eeprom_control_reg <= `DEPW_CTRL_RST;
        end else begin
            if (ctrl_wr) begin
                eeprom_control_reg[`DEPW_CB_RD] <= wb_dat_i[`DEPW_CB_RD];
                eeprom_control_reg[`DEPW_CB_READ_ENABLE_BIT] <= wb_dat_i[`DEPW_CB_READ_ENABLE_BIT];
                eeprom_control_reg[`DEPW_CB_MODE] <= wb_dat_i[`DEPW_CB_MODE];
                eeprom_control_reg[`DEPW_CB_ER] <= wb_dat_i[`DEPW_CB_ER];
                eeprom_control_reg[`DEPW_CB_EREN] <= wb_dat_i[`DEPW_CB_EREN];
                if (!busy) begin
                    eeprom_control_reg[`DEPW_CB_WRITE_ENABLE_BIT] <= wb_dat_i[`DEPW_CB_WRITE_ENABLE_BIT];
                    eeprom_control_reg[`DEPW_CB_WR] <= start_ok;
                end
            end
            if (done) begin
                eeprom_control_reg[`DEPW_CB_WR] <= 1'b0;
                eeprom_control_reg[`DEPW_CB_WRITE_ENABLE_BIT] <= 1'b0;
            end
        end
    end
    // Arming: only the access right after a lone enable-set may start
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (acc) begin
            armed <= ctrl_wr && wb_dat_i[`DEPW_CB_WRITE_ENABLE_BIT] && !wb_dat_i[`DEPW_CB_WR] &&
                     !eeprom_control_reg[`DEPW_CB_WRITE_ENABLE_BIT] && !busy;
        end
    end
    // Enable history for the falling-edge buffer clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            write_enable_bit_q <= 1'b0;
        end else begin
            write_enable_bit_q <= eeprom_control_reg[`DEPW_CB_WRITE_ENABLE_BIT];
        end
    end
    // Address registers; offset advances in hardware, page never does
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            eeprom_addr_low_reg <= 8'h00;
            eeprom_addr_high_reg <= 3'h0;
        end else begin
            if (hit(`DEPW_OFS_ADDR_LO) && !busy) begin
                eeprom_addr_low_reg <= wb_dat_i[7:0];
            end else if (load && offset != `DEPW_OFS_LAST) begin
                eeprom_addr_low_reg[3:0] <= 4'(offset + 4'h1);
            end
            if (hit(`DEPW_OFS_ADDR_HI) && !busy) begin
                eeprom_addr_high_reg <= wb_dat_i[2:0];
            end
        end
    end
    // Data register holds the last byte written for byte mode
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            eeprom_data_reg <= 8'h00;
        end else if (hit(`DEPW_OFS_DATA) && !busy) begin
            eeprom_data_reg <= wb_dat_i[7:0];
        end
    end
    // Pointer high bytes start in sector zero to fence off control
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pointer1_high_byte <= `DEPW_PTRH_RST;
            pointer2_high_byte <= `DEPW_PTRH_RST;
        end else begin
            if (hit(`DEPW_OFS_PTR1H)) begin
                pointer1_high_byte <= wb_dat_i[7:0];
            end
            if (hit(`DEPW_OFS_PTR2H)) begin
                pointer2_high_byte <= wb_dat_i[7:0];
            end
        end
    end
    // Page buffer; the byte at 0FH is taken once, then the buffer is full
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            page_valid <= 16'h0000;
            page_full <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                page_buf[i] <= 8'h00;
            end
        end else if (write_enable_bit_fall) begin
            page_valid <= 16'h0000;
            page_full <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                page_buf[i] <= 8'h00;
            end
        end else begin
            if (hit(`DEPW_OFS_ADDR_LO) && !busy) begin
                page_full <= 1'b0;
            end
            if (load) begin
                page_buf[offset] <= wb_dat_i[7:0];
                page_valid[offset] <= 1'b1;
                if (offset == `DEPW_OFS_LAST) begin
                    page_full <= 1'b1;
                end
            end
        end
    end
    // Sequencer: walk buffer into the array, then wait on the timer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= DEPW_IDLE;
            walk_idx <= 4'h0;
            tmr_start <= 1'b0;
        end else begin
            tmr_start <= 1'b0;
            case (state)
                DEPW_IDLE: begin
                    walk_idx <= 4'h0;
                    if (start_ok) begin
                        state <= DEPW_PROG;
                    end
                end
                DEPW_PROG: begin
                    walk_idx <= 4'(walk_idx + 4'h1);
                    if (!eeprom_control_reg[`DEPW_CB_MODE] || walk_idx == `DEPW_OFS_LAST) begin
                        state <= DEPW_WAIT;
                        tmr_start <= 1'b1;
                    end
                end
                DEPW_WAIT: begin
                    if (tmr_done) begin
                        state <= DEPW_IDLE;
                    end
                end
                default: begin
                    state <= DEPW_IDLE;
                end
            endcase
        end
    end
    // Array port: every loaded slot in page mode, one byte otherwise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            nv_we <= 1'b0;
            nv_addr <= 11'h000;
            nv_wdata <= 8'h00;
        end else if (state == DEPW_PROG && eeprom_control_reg[`DEPW_CB_MODE]) begin
            nv_we <= page_valid[walk_idx];
            nv_addr <= {page_sel, walk_idx};
            nv_wdata <= page_buf[walk_idx];
        end else if (state == DEPW_PROG) begin
            nv_we <= 1'b1;
            nv_addr <= {page_sel, offset};
            nv_wdata <= eeprom_data_reg;
        end else begin
            nv_we <= 1'b0;
        end
    end
    // Interrupt flags: set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 5'h00;
        end else begin
            if (hit(`DEPW_OFS_IRQ)) begin
                irq_reg[`DEPW_IB_GIE] <= wb_dat_i[`DEPW_IB_GIE];
                irq_reg[`DEPW_IB_DEE] <= wb_dat_i[`DEPW_IB_DEE];
                irq_reg[`DEPW_IB_MFE] <= wb_dat_i[`DEPW_IB_MFE];
                if (!wb_dat_i[`DEPW_IB_DEF]) begin
                    irq_reg[`DEPW_IB_DEF] <= 1'b0;
                end
                if (!wb_dat_i[`DEPW_IB_MFF]) begin
                    irq_reg[`DEPW_IB_MFF] <= 1'b0;
                end
            end
            if (irq_service) begin
                irq_reg[`DEPW_IB_MFF] <= 1'b0;
            end
            if (done) begin
                irq_reg[`DEPW_IB_DEF] <= 1'b1;
                irq_reg[`DEPW_IB_MFF] <= 1'b1;
            end
        end
    end
    // Vector request, registered so the output comes from a flop
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_vector_req <= 1'b0;
        end else begin
            irq_vector_req <= irq_reg[`DEPW_IB_GIE] && irq_reg[`DEPW_IB_DEE] &&
                              irq_reg[`DEPW_IB_MFE] && irq_reg[`DEPW_IB_MFF] &&
                              !stack_full;
        end
    end
    depw_wr_timer #(
        .DIV_CYC(TICK_CYC),
        .TICKS(WR_TIME_US)
    ) u_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(tmr_start),
        .busy(tmr_busy),
        .done(tmr_done)
    );
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence arm_s;
        armed && start_ok;
    endsequence
    sequence finish_s;
        state == DEPW_WAIT && tmr_done;
    endsequence
    start_gate_a: assert property ($rose(eeprom_control_reg[`DEPW_CB_WR]) |->
        $past(eeprom_control_reg[`DEPW_CB_WRITE_ENABLE_BIT])) else $error("start bit rose without enable");
    arm_start_a: assert property (arm_s |=> state == DEPW_PROG ##1 tmr_busy || state != DEPW_IDLE)
        else $error("armed start did not run");
    finish_clear_a: assert property (finish_s |=> !eeprom_control_reg[`DEPW_CB_WR] &&
        !eeprom_control_reg[`DEPW_CB_WRITE_ENABLE_BIT]) else $error("cycle end left start or enable set");
    buf_clear_a: assert property (write_enable_bit_fall |=> page_valid == 16'h0000 && !page_full)
        else $error("buffer not cleared on enable fall");
    offset_step_a: assert property (load && offset != `DEPW_OFS_LAST |=>
        offset == 4'($past(offset) + 4'h1) && $stable(page_sel))
        else $error("offset did not step by one");
    offset_sat_a: assert property (page_full && hit(`DEPW_OFS_DATA) && !write_enable_bit_fall |=>
        offset == `DEPW_OFS_LAST && $stable(page_valid))
        else $error("write accepted past page end");
    load_store_a: assert property (
        load && !write_enable_bit_fall |=> page_buf[$past(offset)] == $past(wb_dat_i[7:0]))
        else $error("byte not stored at offset");
    flag_set_a: assert property (
        finish_s |=> irq_reg[`DEPW_IB_DEF] && irq_reg[`DEPW_IB_MFF] ##1 1'b1)
        else $error("cycle end did not raise flags");
    vector_gate_a: assert property (irq_vector_req |-> $past(irq_reg[`DEPW_IB_GIE] &&
        irq_reg[`DEPW_IB_MFE] && irq_reg[`DEPW_IB_DEE] && irq_reg[`DEPW_IB_MFF] && !stack_full))
        else $error("vector request without enables");
    service_clr_a: assert property (irq_service && !done && irq_reg[`DEPW_IB_DEF] |=>
        !irq_reg[`DEPW_IB_MFF] && irq_reg[`DEPW_IB_DEF])
        else $error("service cleared the wrong flag");
    busy_hold_a: assert property (busy && !done |-> eeprom_control_reg[`DEPW_CB_WR])
        else $error("start bit dropped while busy");
endmodule

// ==== depw_map.svh ====
/*
 Register map, field positions, reset values and timing counts
 for the data EEPROM page write controller.
 Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
`ifndef DEPW_MAP_SVH
`define DEPW_MAP_SVH

// Register byte offsets
`define DEPW_OFS_CTRL 8'h00
`define DEPW_OFS_ADDR_LO 8'h04
`define DEPW_OFS_ADDR_HI 8'h08
`define DEPW_OFS_DATA 8'h0c
`define DEPW_OFS_PTR1H 8'h10
`define DEPW_OFS_PTR2H 8'h14
`define DEPW_OFS_IRQ 8'h18

// Control register fields
`define DEPW_CB_RD 0
`define DEPW_CB_READ_ENABLE_BIT 1
`define DEPW_CB_WR 2
`define DEPW_CB_WRITE_ENABLE_BIT 3
`define DEPW_CB_MODE 4
`define DEPW_CB_ER 5
`define DEPW_CB_EREN 6

// Interrupt register fields
`define DEPW_IB_GIE 0
`define DEPW_IB_DEE 1
`define DEPW_IB_MFE 2
`define DEPW_IB_DEF 3
`define DEPW_IB_MFF 4

// Reset values and sector holding the control register
`define DEPW_CTRL_RST 7'h00
`define DEPW_PTRH_RST 8'h00
`define DEPW_SECTOR_CTRL 8'h01
`define DEPW_OFS_LAST 4'hf

// Timing: 250 MHz clock, 1 us timer tick, write cycle time
`define DEPW_CLK_NS 4
`define DEPW_TICK_NS 1000
`define DEPW_TICK_CYC (`DEPW_TICK_NS / `DEPW_CLK_NS)
`define DEPW_WR_TIME_US 2000

`endif

// ==== depw_pkg.sv ====
/*
 Types shared by the data EEPROM page write controller.
 Assumes depw_map.svh supplies the numeric constants.
*/
package depw_pkg;
    // Write sequencer states
    typedef enum logic [1:0] {
        DEPW_IDLE = 2'b00,
        DEPW_PROG = 2'b01,
        DEPW_WAIT = 2'b10
    } depw_state_t;
    typedef logic [7:0] depw_byte_t;
endpackage

// ==== depw_wr_timer.sv ====
/*
 Self-timed write cycle timer for the EEPROM controller.
 Assumes one start pulse per cycle, taken only while idle.
*/
`timescale 1ns/10ps
`include "depw_map.svh"

module depw_wr_timer #(
    parameter int DIV_CYC = `DEPW_TICK_CYC,
    parameter int TICKS = `DEPW_WR_TIME_US
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [15:0] div_cnt;
    logic [15:0] tick_cnt;
    logic tick;

    // Free running divider: the cycle time runs apart from bus timing
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (div_cnt == 16'(DIV_CYC - 1)) begin
            div_cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            div_cnt <= 16'(div_cnt + 16'h0001);
            tick <= 1'b0;
        end
    end

    // Tick counter; start may land mid-tick, so time is at least TICKS-1 ticks
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            done <= 1'b0;
            tick_cnt <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                tick_cnt <= 16'h0000;
            end else if (busy && tick) begin
                if (tick_cnt == 16'(TICKS - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    tick_cnt <= 16'(tick_cnt + 16'h0001);
                end
            end
        end
    end
endmodule

// ==== depw_nv_model.sv ====
/*
 Behavioural model of the EEPROM array behind the program port.
 Assumes one byte per nv_we pulse; an erased cell holds zero.
*/
`timescale 1ns/10ps

module depw_nv_model (
    // Clock
    input wire logic ref_clk,
    // Program port
    input wire logic nv_we,
    input wire logic [10:0] nv_addr,
    input wire logic [7:0] nv_wdata
);
    logic [7:0] mem [0:2047];
    int writes;

    // Array starts erased, so stale data never fakes a match
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        writes = 0;
    end

    // Store each programmed byte and count the pulses
    always @(posedge ref_clk) begin
        if (nv_we === 1'b1) begin
            mem[nv_addr] <= nv_wdata;
            writes <= writes + 1;
        end
    end
endmodule

// ==== tb_data_eeprom_page_write_ctrl.sv ====
/*
 Self-checking bench for the page write controller.
 Assumes the controller answers every Wishbone request and the
 array model counts each programmed byte.
*/
`timescale 1ns/10ps
`include "depw_map.svh"

module tb_data_eeprom_page_write_ctrl;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic stack_full = 1'b0;
    logic irq_service = 1'b0;
    logic irq_vector_req;
    logic nv_we;
    logic [10:0] nv_addr;
    logic [7:0] nv_wdata;
    logic [31:0] rd;
    int fail_count = 0;
    int compares = 0;
    int base;

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    // Short timer so a write cycle lasts a few dozen clocks
    depw_ctrl #(.WR_TIME_US(3), .TICK_CYC(4)) dut_u (
        .ref_clk(ref_clk), .nrst(nrst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .stack_full(stack_full), .irq_service(irq_service),
        .irq_vector_req(irq_vector_req),
        .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata)
    );

    depw_nv_model nv_u (
        .ref_clk(ref_clk), .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata)
    );

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task final_report;
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One classic cycle, held until ack is sampled high
    task wbx(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_sel_i <= 4'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_sel_i <= 4'h0;
        if (n >= 64) fail_count++;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        wbx(1'b0, a, 8'h00);
        check(rd, exp);
    endtask

    // Interrupts masked around the enable-then-start pair
    task begin_write(input logic [7:0] mode);
        wbx(1'b1, `DEPW_OFS_IRQ, 8'h06);
        wbx(1'b1, `DEPW_OFS_CTRL, mode | 8'h08);
        wbx(1'b1, `DEPW_OFS_CTRL, mode | 8'h0c);
        wbx(1'b1, `DEPW_OFS_IRQ, 8'h07);
    endtask

    // Poll the start bit; both start and enable must be gone
    task wait_done(input logic [7:0] mode);
        int n;
        n = 0;
        do begin
            wbx(1'b0, `DEPW_OFS_CTRL, 8'h00);
            n++;
        end while (rd[2] === 1'b1 && n < 100);
        check(rd, {24'h0, mode});
    endtask

    task power_on;
        rdc(`DEPW_OFS_PTR1H, 32'h0);
        rdc(`DEPW_OFS_PTR2H, 32'h0);
        wbx(1'b1, `DEPW_OFS_CTRL, 8'h18);
        wbx(1'b1, `DEPW_OFS_PTR1H, 8'h01);
        rdc(`DEPW_OFS_CTRL, 32'h0);
        rdc(8'h1c, 32'h0);
        begin_write(8'h10);
        wait_done(8'h10);
        check(nv_u.writes, 0);
    endtask

    task page_write;
        base = nv_u.writes;
        wbx(1'b1, `DEPW_OFS_ADDR_HI, 8'h02);
        wbx(1'b1, `DEPW_OFS_ADDR_LO, 8'h50);
        for (int i = 0; i < 3; i++) begin
            wbx(1'b1, `DEPW_OFS_DATA, 8'h30 + 8'(i));
        end
        rdc(`DEPW_OFS_ADDR_LO, 32'h53);
        rdc(`DEPW_OFS_ADDR_HI, 32'h02);
        begin_write(8'h10);
        wbx(1'b1, `DEPW_OFS_DATA, 8'h77);
        rdc(`DEPW_OFS_CTRL, 32'h1c);
        wait_done(8'h10);
        check(nv_u.writes, base + 3);
        for (int i = 0; i < 3; i++) begin
            check(nv_u.mem[11'h250 + 11'(i)], 8'h30 + 8'(i));
        end
        check(nv_u.mem[11'h253], 8'h00);
        rdc(`DEPW_OFS_IRQ, 32'h1f);
        check(irq_vector_req, 1'b1);
        @(posedge ref_clk);
        stack_full <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(irq_vector_req, 1'b0);
        stack_full <= 1'b0;
        @(posedge ref_clk);
        irq_service <= 1'b1;
        @(posedge ref_clk);
        irq_service <= 1'b0;
        rdc(`DEPW_OFS_IRQ, 32'h0f);
        check(irq_vector_req, 1'b0);
        wbx(1'b1, `DEPW_OFS_IRQ, 8'h07);
        rdc(`DEPW_OFS_IRQ, 32'h07);
    endtask

    task offset_saturates;
        base = nv_u.writes;
        wbx(1'b1, `DEPW_OFS_ADDR_LO, 8'h5d);
        for (int i = 0; i < 4; i++) begin
            wbx(1'b1, `DEPW_OFS_DATA, 8'h40 + 8'(i));
        end
        rdc(`DEPW_OFS_ADDR_LO, 32'h5f);
        begin_write(8'h10);
        wait_done(8'h10);
        check(nv_u.writes, base + 3);
        check(nv_u.mem[11'h25f], 8'h42);
    endtask

    // Start alone, then start after a gap, then a cleared buffer
    task start_refused;
        base = nv_u.writes;
        wbx(1'b1, `DEPW_OFS_ADDR_LO, 8'h60);
        wbx(1'b1, `DEPW_OFS_DATA, 8'h55);
        wbx(1'b1, `DEPW_OFS_CTRL, 8'h14);
        wbx(1'b1, `DEPW_OFS_CTRL, 8'h18);
        rdc(`DEPW_OFS_ADDR_HI, 32'h02);
        wbx(1'b1, `DEPW_OFS_CTRL, 8'h1c);
        repeat (40) @(posedge ref_clk);
        check(nv_u.writes, base);
        wbx(1'b1, `DEPW_OFS_CTRL, 8'h10);
        begin_write(8'h10);
        wait_done(8'h10);
        check(nv_u.writes, base);
        check(nv_u.mem[11'h260], 8'h00);
    endtask

    task byte_write;
        base = nv_u.writes;
        wbx(1'b1, `DEPW_OFS_ADDR_HI, 8'h01);
        wbx(1'b1, `DEPW_OFS_ADDR_LO, 8'h23);
        wbx(1'b1, `DEPW_OFS_CTRL, 8'h00);
        wbx(1'b1, `DEPW_OFS_DATA, 8'ha5);
        begin_write(8'h00);
        wait_done(8'h00);
        check(nv_u.writes, base + 1);
        check(nv_u.mem[11'h123], 8'ha5);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        power_on;
        page_write;
        offset_saturates;
        start_refused;
        byte_write;
        final_report;
    end

    // Watchdog, well beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        final_report;
    end
endmodule
